// file: pc_card_status_change_irq.sv
// Card status change detection, interrupt gating and register slave.
//
// Summary of operation
// - Only card pin events set status flags; software may set only bit 7.
// - Status flags clear on power-on reset only, held otherwise.
// - Writing 1 to bit 7 raises the detect interrupt when enable bit 3 set.
// - Reserved bits 6 to 4 read zero; software writes zero there.
// - Detect change flag sets whenever either card-detect pin changes.
// - Writing 0 clears a hardware flag; writing 1 leaves it.
// - Memory card: ready flag sets only on ready pin rising 0 to 1.
// - On an I/O card the ready flag reads as zero.
// - Warning flag sets when second battery pin 0 and first pin 1.
// - Dead flag sets when first battery pin is 0.
// - Battery flags re-evaluated whenever either battery pin changes.
// - Enable bits 3 to 0 each pass their status interrupt when 1, block when 0.
// - Enable register clears on power-on reset only, held otherwise.
// - Enable bit 7 with a card inserted reinitialises the general control.
// - Enable bit 3 gates the card-detect change interrupt.
// - Memory card: enable bit 2 gates the ready rising interrupt.
// - Memory card: enable bit 1 gates the battery warning interrupt.
// - Enable bit 0 gates the battery dead interrupt.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "pcc_irq_map.svh"

module pc_card_status_change_irq
    import pcc_irq_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and power-on reset.
    input  wire logic              CLK,
    input  wire logic              RSTN,

    // AXI4-Lite write address channel.
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output      logic              S_AXI_AWREADY,

    // AXI4-Lite write data channel.
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output      logic              S_AXI_WREADY,

    // AXI4-Lite write response channel.
    output      logic [1:0]        S_AXI_BRESP,
    output      logic              S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,

    // AXI4-Lite read address channel.
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output      logic              S_AXI_ARREADY,

    // AXI4-Lite read data channel.
    output      logic [31:0]       S_AXI_RDATA,
    output      logic [1:0]        S_AXI_RRESP,
    output      logic              S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,

    // Card socket pins, active-low card detect as on the socket.
    input  wire logic              CARD_DETECT1_N,
    input  wire logic              CARD_DETECT2_N,
    input  wire logic              CARD_READY,
    input  wire logic              CARD_BATTERY1,
    input  wire logic              CARD_BATTERY2,
    input  wire logic              IO_CARD_MODE,

    // Interrupt request and general control reinitialise pulse.
    output      logic              CARD_IRQ,
    output      logic              GENERAL_CONTROL_REINIT
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    typedef enum logic [2:0]
    {
        SEL_FLAGS  = 3'b001,
        SEL_ENABLE = 3'b010,
        SEL_NONE   = 3'b100
    } reg_sel_e;

    function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
        reg_sel_e sel;
        if (addr == ADDR_W'(`PCC_FLAGS_OFFSET))
            sel = SEL_FLAGS;
        else if (addr == ADDR_W'(`PCC_ENABLE_OFFSET))
            sel = SEL_ENABLE;
        else
            sel = SEL_NONE;
        return sel;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    // Storage.

    byte_reg_t             flags_reg;
    byte_reg_t             flags_next;
    byte_reg_t             enable_reg;
    byte_reg_t             flags_view;
    logic                  primed_reg;
    logic                  det1_prev_reg;
    logic                  det2_prev_reg;
    logic                  ready_prev_reg;
    logic                  bat1_prev_reg;
    logic                  bat2_prev_reg;
    logic                  reinit_reg;
    logic                  irq_reg;

    logic                  aw_held_reg;
    logic [ADDR_W-1:0]     aw_addr_reg;
    logic                  w_held_reg;
    logic [31:0]           w_data_reg;
    logic [3:0]            w_strb_reg;
    logic                  bvalid_reg;
    axi_resp_e             bresp_reg;
    logic                  rvalid_reg;
    logic [31:0]           rdata_reg;
    axi_resp_e             rresp_reg;

    logic                  write_fire;
    reg_sel_e              write_sel;
    logic                  flags_wr;
    logic                  enable_wr;
    logic                  detect_change;
    logic                  ready_rise;
    logic                  battery_eval;
    logic                  card_present;
    byte_reg_t             set_events;

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and event detection.

    // The first cycle after reset flags no detect or ready change, so a card that is
    // already seated does not look like a fresh change.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            primed_reg     <= 1'b0;
            det1_prev_reg  <= 1'b1;
            det2_prev_reg  <= 1'b1;
            ready_prev_reg <= 1'b0;
            bat1_prev_reg  <= 1'b0;
            bat2_prev_reg  <= 1'b0;
        end
        else
        begin
            primed_reg     <= 1'b1;
            det1_prev_reg  <= CARD_DETECT1_N;
            det2_prev_reg  <= CARD_DETECT2_N;
            ready_prev_reg <= CARD_READY;
            bat1_prev_reg  <= CARD_BATTERY1;
            bat2_prev_reg  <= CARD_BATTERY2;
        end
    end

    assign detect_change = primed_reg &&
                           ((CARD_DETECT1_N != det1_prev_reg) ||
                            (CARD_DETECT2_N != det2_prev_reg));
    assign ready_rise    = primed_reg && !IO_CARD_MODE &&
                           CARD_READY && !ready_prev_reg;
    // Battery state is judged once on the first sample and then on change.
    assign battery_eval  = !primed_reg ||
                           (CARD_BATTERY1 != bat1_prev_reg) ||
                           (CARD_BATTERY2 != bat2_prev_reg);
    assign card_present  = !CARD_DETECT1_N && !CARD_DETECT2_N;

    always_comb
    begin
        set_events = 8'h00;
        set_events[`PCC_BIT_DETECT] = detect_change;
        set_events[`PCC_BIT_READY]  = ready_rise;
        set_events[`PCC_BIT_WARN]   = battery_eval && CARD_BATTERY1 &&
                                      !CARD_BATTERY2;
        set_events[`PCC_BIT_DEAD]   = battery_eval && !CARD_BATTERY1;
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path.

    assign write_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign write_sel  = decode(aw_addr_reg);
    assign flags_wr   = write_fire && (write_sel == SEL_FLAGS) &&
                        w_strb_reg[0];
    assign enable_wr  = write_fire && (write_sel == SEL_ENABLE) &&
                        w_strb_reg[0];

    assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
    assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
        end
        else if (write_fire)
        begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end
        else if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_held_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
        end
        else if (write_fire)
        begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end
        else if (write_fire)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (write_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (S_AXI_BREADY)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and enable registers.

    // A pin event in the same cycle as a clearing write keeps its flag set.
    always_comb
    begin
        flags_next = flags_reg;
        if (flags_wr)
        begin
            flags_next = flags_reg & w_data_reg[7:0] &
                         `PCC_HW_FLAG_MASK;
            flags_next[`PCC_BIT_SOFT_DETECT] =
                w_data_reg[`PCC_BIT_SOFT_DETECT];
        end
        flags_next = (flags_next | set_events) & `PCC_IMPL_MASK;
    end

    // Only the power-on reset reaches these flip-flops.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            flags_reg <= `PCC_FLAGS_RESET;
        else
            flags_reg <= flags_next;
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            enable_reg <= `PCC_ENABLE_RESET;
        else if (enable_wr)
            enable_reg <= w_data_reg[7:0] & `PCC_IMPL_MASK;
    end

    // The ready flag is hidden while the socket runs as an I/O card.
    always_comb
    begin
        flags_view = flags_reg;
        if (IO_CARD_MODE)
            flags_view[`PCC_BIT_READY] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt and general control reinitialise.

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= (enable_reg[`PCC_BIT_DETECT] &&
                        (flags_reg[`PCC_BIT_DETECT] ||
                         flags_reg[`PCC_BIT_SOFT_DETECT]))
                    || (enable_reg[`PCC_BIT_READY] &&
                        flags_view[`PCC_BIT_READY])
                    || (enable_reg[`PCC_BIT_WARN] &&
                        flags_reg[`PCC_BIT_WARN])
                    || (enable_reg[`PCC_BIT_DEAD] &&
                        flags_reg[`PCC_BIT_DEAD]);
        end
    end

    assign CARD_IRQ = irq_reg;

    // One pulse each time the detect pins change into the inserted state while enable bit 7 is set.
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            reinit_reg <= 1'b0;
        else
            reinit_reg <= enable_reg[`PCC_BIT_REINIT] && detect_change &&
                          card_present;
    end

    assign GENERAL_CONTROL_REINIT = reinit_reg;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path.

    assign S_AXI_ARREADY = !rvalid_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            if (decode(S_AXI_ARADDR) == SEL_FLAGS)
            begin
                rdata_reg <= {24'h00_0000, flags_view};
            end
            else if (decode(S_AXI_ARADDR) == SEL_ENABLE)
            begin
                rdata_reg <= {24'h00_0000, enable_reg};
            end
            else
            begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= RESP_SLVERR;
            end
        end
        else if (S_AXI_RREADY)
        begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule : pc_card_status_change_irq

// file: pcc_irq_map.svh
// Register offsets, field positions and reset values of the card status block.
`ifndef PCC_IRQ_MAP_SVH
`define PCC_IRQ_MAP_SVH

`define PCC_FLAGS_OFFSET      8'h00
`define PCC_ENABLE_OFFSET     8'h04

`define PCC_FLAGS_RESET       8'h00
`define PCC_ENABLE_RESET      8'h00

`define PCC_BIT_SOFT_DETECT   7
`define PCC_BIT_REINIT        7
`define PCC_BIT_DETECT        3
`define PCC_BIT_READY         2
`define PCC_BIT_WARN          1
`define PCC_BIT_DEAD          0

`define PCC_HW_FLAG_MASK      8'h0f
`define PCC_IMPL_MASK         8'h8f

`endif

// file: pcc_irq_pkg.sv
// Types shared by the card status change interrupt block.
package pcc_irq_pkg;

    typedef logic [7:0] byte_reg_t;

    typedef enum logic [1:0]
    {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_e;

endpackage : pcc_irq_pkg

// file: pc_card_status_change_irq_checker.sv
// Port-level assertions for the card status change block.
`timescale 1ns/1ps
module pc_card_status_change_irq_checker
    import pcc_irq_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Watched ports, all inputs.
    input wire logic CLK, RSTN,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR,
    input wire logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID,
    input wire logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY,
    input wire logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
    input wire logic S_AXI_RREADY, CARD_DETECT1_N, CARD_DETECT2_N,
    input wire logic CARD_READY, CARD_BATTERY1, CARD_BATTERY2,
    input wire logic IO_CARD_MODE, CARD_IRQ, GENERAL_CONTROL_REINIT,
    input wire logic [31:0] S_AXI_WDATA, S_AXI_RDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic [1:0] S_AXI_BRESP, S_AXI_RRESP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    chk_rsvd_zero: assert property (
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0 && !(|S_AXI_RDATA[6:4]))
        else $error("Reserved read bits are not zero.");
    chk_reinit_cause: assert property (
        GENERAL_CONTROL_REINIT |-> $past(!CARD_DETECT1_N && !CARD_DETECT2_N))
        else $error("Reinit pulse without a seated card.");
    chk_reinit_pulse: assert property (
        GENERAL_CONTROL_REINIT |=> !GENERAL_CONTROL_REINIT)
        else $error("Reinit pulse longer than one cycle.");
    chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID)
        else $error("Write response late.");
    chk_b_release: assert property (
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("Write response held after acceptance.");
    chk_read_answer: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("Read response late.");
    chk_r_release: assert property (
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("Read response held after acceptance.");
    chk_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("Read address taken while data pending.");
endmodule : pc_card_status_change_irq_checker

bind pc_card_status_change_irq pc_card_status_change_irq_checker
    #(.ADDR_W(ADDR_W)) u_checker
(
    .CLK(CLK), .RSTN(RSTN),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .CARD_DETECT1_N(CARD_DETECT1_N), .CARD_DETECT2_N(CARD_DETECT2_N),
    .CARD_READY(CARD_READY), .CARD_BATTERY1(CARD_BATTERY1),
    .CARD_BATTERY2(CARD_BATTERY2), .IO_CARD_MODE(IO_CARD_MODE),
    .CARD_IRQ(CARD_IRQ),
    .GENERAL_CONTROL_REINIT(GENERAL_CONTROL_REINIT),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_RRESP(S_AXI_RRESP)
);

// file: pc_card_model.sv
// Behavioural PC card seated in the socket.
`timescale 1ns/1ps
module pc_card_model
(
    // Commands from the bench.
    input  wire logic CLK,
    input  wire logic seat, rdy, bat1, bat2,
    // Socket pins.
    output logic      CARD_DETECT1_N = 1'b1, CARD_DETECT2_N = 1'b1,
    output logic      CARD_READY = 1'b0,
    output logic      CARD_BATTERY1 = 1'b1, CARD_BATTERY2 = 1'b1
);
    // Pins move just after an edge; both detect contacts close together.
    always @(posedge CLK)
    begin
        CARD_DETECT1_N <= !seat;
        CARD_DETECT2_N <= !seat;
        CARD_READY     <= rdy;
        CARD_BATTERY1  <= bat1;
        CARD_BATTERY2  <= bat2;
    end
endmodule : pc_card_model

// file: pc_card_status_change_irq_bench.sv
// Self-checking bench for the card status change block.
`timescale 1ns/1ps
`include "pcc_irq_map.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
    n_mismatch++; $display("ERROR %s exp %h got %h", n, e, s); end end
module pc_card_status_change_irq_bench;
    import pcc_irq_pkg::*;
    localparam logic [7:0] flg = `PCC_FLAGS_OFFSET;
    localparam logic [7:0] ena = `PCC_ENABLE_OFFSET;
    logic CLK = 1'b0, RSTN = 1'b0;
    logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hf;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b1;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b1, IO_CARD_MODE = 1'b0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, CARD_IRQ, GENERAL_CONTROL_REINIT;
    logic CARD_DETECT1_N, CARD_DETECT2_N, CARD_READY;
    logic CARD_BATTERY1, CARD_BATTERY2;
    logic seat = 1'b0, rdy = 1'b0, bat1 = 1'b1, bat2 = 1'b1;
    logic [7:0] rv, d;
    logic [1:0] rs;
    logic [1:0] tbl [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
    logic seen;
    int n_mismatch = 0, compares = 0, seed = 76, i;

    pc_card_status_change_irq u_pc_card_status_change_irq
    (
        .CLK(CLK), .RSTN(RSTN),
        .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
        .S_AXI_AWREADY(S_AXI_AWREADY),
        .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
        .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
        .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
        .S_AXI_BREADY(S_AXI_BREADY),
        .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
        .S_AXI_ARREADY(S_AXI_ARREADY),
        .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
        .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
        .CARD_DETECT1_N(CARD_DETECT1_N), .CARD_DETECT2_N(CARD_DETECT2_N),
        .CARD_READY(CARD_READY), .CARD_BATTERY1(CARD_BATTERY1),
        .CARD_BATTERY2(CARD_BATTERY2), .IO_CARD_MODE(IO_CARD_MODE),
        .CARD_IRQ(CARD_IRQ),
        .GENERAL_CONTROL_REINIT(GENERAL_CONTROL_REINIT)
    );
    pc_card_model u_pc_card_model
    (
        .CLK(CLK), .seat(seat), .rdy(rdy), .bat1(bat1), .bat2(bat2),
        .CARD_DETECT1_N(CARD_DETECT1_N), .CARD_DETECT2_N(CARD_DETECT2_N),
        .CARD_READY(CARD_READY), .CARD_BATTERY1(CARD_BATTERY1),
        .CARD_BATTERY2(CARD_BATTERY2)
    );

    always #10 CLK = ~CLK;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] bat_flags(logic b1, logic b2);
        return {6'h0, b1 & !b2, !b1};
    endfunction : bat_flags

    function automatic logic irq_exp(logic [7:0] f, logic [7:0] e, logic io);
        return |(e[3:0] & {f[3] | f[7], f[2] & !io, f[1], f[0]});
    endfunction : irq_exp

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask : tick

    task automatic watch(output logic s);
        s = 1'b0;
        repeat (6)
        begin
            @(posedge CLK);
            if (GENERAL_CONTROL_REINIT === 1'b1) s = 1'b1;
        end
    endtask : watch

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= {24'h0, v};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        do
        begin
            @(posedge CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end
        while (!S_AXI_BVALID);
        rs = S_AXI_BRESP;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        do
        begin
            @(posedge CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end
        while (!S_AXI_RVALID);
        rv = S_AXI_RDATA[7:0];
        rs = S_AXI_RRESP;
    endtask : rd

    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
        rd(a);
        `CHK(n, e, rv);
    endtask : rc

    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        n_mismatch++;
        results();
    end

    initial
    begin
        tick(2);
        RSTN <= 1'b1;
        tick(2);
        rc("flags", flg, 8'h00);
        rc("enable", ena, 8'h00);
        wr(8'h08, 8'h8f);
        `CHK("bresp", RESP_SLVERR, rs);
        rc("unmapped", 8'h08, 8'h00);
        `CHK("rresp", RESP_SLVERR, rs);
        S_AXI_WSTRB <= 4'he;
        wr(ena, 8'h8f);
        S_AXI_WSTRB <= 4'hf;
        `CHK("bresp", RESP_OKAY, rs);
        rc("enable", ena, 8'h00);
        $display("test reset_unmapped done");
        wr(flg, 8'h80);
        `CHK("bresp", RESP_OKAY, rs);
        rc("flags", flg, 8'h80);
        `CHK("rresp", RESP_OKAY, rs);
        for (i = 0; i < 10; i++)
        begin
            d = $random(seed) & `PCC_IMPL_MASK;
            if (i < 2) d = (i == 0) ? 8'h08 : 8'h87;
            wr(ena, d);
            rc("enable", ena, d);
            tick(2);
            `CHK("irq", irq_exp(8'h80, d, 1'b0), CARD_IRQ);
        end
        wr(flg, 8'h00);
        $display("test soft_detect done");
        wr(ena, 8'h80);
        seat <= 1'b1;
        watch(seen);
        `CHK("reinit", 1'b1, seen);
        rc("flags", flg, 8'h08);
        `CHK("irq", 1'b0, CARD_IRQ);
        wr(ena, 8'h08);
        tick(2);
        `CHK("irq", 1'b1, CARD_IRQ);
        wr(flg, 8'h08);
        rc("flags", flg, 8'h08);
        wr(flg, 8'h00);
        rc("flags", flg, 8'h00);
        tick(2);
        `CHK("irq", 1'b0, CARD_IRQ);
        seat <= 1'b0;
        tick(4);
        rc("flags", flg, 8'h08);
        `CHK("irq", 1'b1, CARD_IRQ);
        wr(flg, 8'h00);
        seat <= 1'b1;
        watch(seen);
        `CHK("reinit", 1'b0, seen);
        rc("flags", flg, 8'h08);
        wr(flg, 8'h00);
        $display("test detect done");
        wr(ena, 8'h04);
        rdy <= 1'b1;
        tick(4);
        rc("flags", flg, 8'h04);
        `CHK("irq", 1'b1, CARD_IRQ);
        IO_CARD_MODE <= 1'b1;
        tick(2);
        rc("flags", flg, 8'h00);
        `CHK("irq", 1'b0, CARD_IRQ);
        IO_CARD_MODE <= 1'b0;
        wr(flg, 8'h00);
        rdy <= 1'b0;
        tick(4);
        rc("flags", flg, 8'h00);
        IO_CARD_MODE <= 1'b1;
        rdy <= 1'b1;
        tick(4);
        rc("flags", flg, 8'h00);
        `CHK("irq", 1'b0, CARD_IRQ);
        IO_CARD_MODE <= 1'b0;
        wr(flg, 8'h00);
        $display("test ready done");
        wr(ena, 8'h03);
        for (i = 0; i < 4; i++)
        begin
            wr(flg, 8'h00);
            bat1 <= tbl[i][1];
            bat2 <= tbl[i][0];
            tick(4);
            d = bat_flags(tbl[i][1], tbl[i][0]);
            rc("battery", flg, d);
            `CHK("irq", irq_exp(d, 8'h03, 1'b0), CARD_IRQ);
        end
        $display("test battery done");
        wr(flg, 8'h80);
        wr(ena, 8'h88);
        tick(2);
        `CHK("irq", 1'b1, CARD_IRQ);
        RSTN <= 1'b0;
        tick(2);
        RSTN <= 1'b1;
        tick(2);
        rc("flags", flg, 8'h00);
        rc("enable", ena, 8'h00);
        `CHK("irq", 1'b0, CARD_IRQ);
        $display("test mid_reset done");
        results();
    end
endmodule : pc_card_status_change_irq_bench
